/* File: core/tss_pkg.sv */
// Function
// - Logon may only start while the terminal sits in the receive-sync state.
// - Entry runs logon, optional coarse sync, optional fine sync, then maintenance.
// - A message with transmit-disable set in any synced state logs off into hold.
// - Hold is stored in non-volatile form and is restored after power cycle or reset.
// - Only a message with transmit-disable clear releases hold into receive-sync.
// - Traffic bursts stay suppressed until the fine-sync state is reached.
// - After power-up the local clock is initialised by tracking the clock reference.
// - Range and delay come from the position table, else from the nominal position.
// - Losing the reference outside hold stops transmission and restarts initial sync.
// - Any failure in logon, coarse, fine or maintenance restarts initial sync.
// - The burst time plan and the broadcast message are taken before initial sync passes to receive-sync.
// - Ready-for-coarse follows detection and runs the coarse procedure.
// - Ready-for-fine follows detection and runs fine sync towards fine-sync.
// - A logon ack without an acquisition descriptor skips coarse sync.
// - Fine sync runs only when the latest errors exceed the fine thresholds.
// - Logoff ceases every transmission and releases address and sync slot.
package tss_pkg;

   // Terminal states, one-hot
   typedef enum logic [7:0] {
      ST_INACTIVE  = 8'h01,
      ST_INIT      = 8'h02,
      ST_HOLD      = 8'h04,
      ST_RX_SYNC   = 8'h08,
      ST_LOGON     = 8'h10,
      ST_COARSE    = 8'h20,
      ST_FINE_RDY  = 8'h40,
      ST_FINE_SYNC = 8'h80
   } tss_state_t;

   // Clock and timing
   localparam int CLK_FREQ_HZ = 250_000_000;
   localparam int SEC_CYCLES = CLK_FREQ_HZ;
   localparam int LOGON_WAIT_MS = 500;
   localparam int LOGON_WAIT_CYC = LOGON_WAIT_MS * (CLK_FREQ_HZ / 1000);

   // Propagation delay per km of range, in ns
   localparam int KMW = 12;
   localparam logic [KMW-1:0] NS_PER_KM = 12'hd08;

   // Reference lock and start-up sampling
   localparam logic [3:0] NCR_LOCK_COUNT = 4'h3;
   localparam logic [1:0] BOOT_SAMPLE = 2'h2;
   localparam logic [1:0] BOOT_DONE = 2'h3;

   // Values after reset
   localparam tss_state_t STATE_RST = ST_INACTIVE;
   localparam logic [7:0] TRIES_RST = 8'h00;
   localparam logic [3:0] MISS_RST = 4'h0;

endpackage

/* File: core/tss_sync2.sv */
`timescale 1ns/100ps
`default_nettype none
// Two-stage synchroniser for levels from another domain
module tss_sync2 #(
   parameter int WIDTH = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Data
   input wire logic [WIDTH-1:0] d_in,
   output logic [WIDTH-1:0] d_out
);

   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] meta_d;
   logic [WIDTH-1:0] sync_q;
   logic [WIDTH-1:0] sync_d;

   // First stage feeds only the second
   always_comb begin
      meta_d = d_in;
      sync_d = meta_q;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= meta_d;
         sync_q <= sync_d;
      end
   end

   assign d_out = sync_q;

endmodule // tss_sync2
`default_nettype wire

/* File: core/tss_sync_fsm.sv */
`timescale 1ns/100ps
`default_nettype none
// Network entry and synchronisation sequencer of a return channel terminal
module tss_sync_fsm
   import tss_pkg::*;
#(
   parameter int SEC_CYC = SEC_CYCLES,
   parameter int LOGON_CYC = LOGON_WAIT_CYC,
   parameter int NW = 32,
   parameter int PW = 16,
   parameter int EW = 16,
   parameter int MISS_MAX = 4,
   parameter int NCR_TOL = 16
) (
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Clock reference, in core clock units
   input wire logic NCR_VALID,
   input wire logic [NW-1:0] NCR_VALUE,
   input wire logic [3:0] NCR_TIMEOUT_S,
   // Satellite position and own location
   input wire logic SPT_VALID,
   input wire logic NIT_VALID,
   input wire logic [PW-1:0] SAT_X,
   input wire logic [PW-1:0] SAT_Y,
   input wire logic [PW-1:0] SAT_Z,
   input wire logic [PW-1:0] TERM_X,
   input wire logic [PW-1:0] TERM_Y,
   input wire logic [PW-1:0] TERM_Z,
   // Burst time plan and terminal info message
   input wire logic BTP_VALID,
   input wire logic TIM_VALID,
   input wire logic TIM_TX_DISABLE,
   input wire logic TIM_LOGON_ACK,
   input wire logic TIM_ACQ_DESC,
   // Corrections and thresholds
   input wire logic CORR_VALID,
   input wire logic [EW-1:0] CORR_ERR_T,
   input wire logic [EW-1:0] CORR_ERR_F,
   input wire logic [EW-1:0] COARSE_THR_T,
   input wire logic [EW-1:0] COARSE_THR_F,
   input wire logic [EW-1:0] FINE_THR_T,
   input wire logic [EW-1:0] FINE_THR_F,
   input wire logic [7:0] MAX_TRIES,
   // Terminal control
   input wire logic LOGON_START,
   input wire logic LOGOFF_REQ,
   input wire logic SYNC_SENT,
   // Non-volatile hold store
   input wire logic NV_HOLD_IN,
   output logic NV_HOLD_WR,
   output logic NV_HOLD_DATA,
   // State and transmit control
   output logic [7:0] STATE,
   output logic TRAFFIC_TX_EN,
   output logic ACQ_TX_EN,
   output logic SYNC_TX_EN,
   output logic LOGON_REQ,
   output logic LOGGED_ON,
   // Status events
   output logic NCR_LOCKED,
   output logic NCR_LOSS_EVT,
   output logic PROC_FAIL_EVT,
   // Range results
   output logic RANGE_VALID,
   output logic [PW+1:0] RANGE_KM,
   output logic [PW+KMW+1:0] PROP_DELAY_NS
);

   localparam int SW = PW + 1;
   localparam int RW = SW + 1;
   localparam int AW = 2 * RW;
   localparam int DW = RW + KMW;
   localparam int SCW = $clog2(SEC_CYC + 1);
   localparam int LCW = $clog2(LOGON_CYC + 1);
   localparam int BW = $clog2(RW);

   // Threshold test on the latest correction
   function automatic logic over_thr(input logic [EW-1:0] et,
                                     input logic [EW-1:0] ef,
                                     input logic [EW-1:0] tt,
                                     input logic [EW-1:0] tf);
      return (et > tt) || (ef > tf);
   endfunction

   logic nv_hold_s;

   // Hold store level comes from another domain
   tss_sync2 #(
      .WIDTH(1)
   ) u_nv_sync (
      .clk(CORE_CLK),
      .rst_n(RESET_N),
      .d_in(NV_HOLD_IN),
      .d_out(nv_hold_s)
   );

   // ---------------- Clock reference tracking ----------------
   logic [NW-1:0] local_q, local_d;
   logic [3:0] good_q, good_d;
   logic locked_q, locked_d;
   logic [SCW-1:0] sec_q, sec_d;
   logic [3:0] age_q, age_d;
   logic loss_q, loss_d;
   logic [NW-1:0] ncr_err;
   logic ncr_bad;

   // Local clock loads from the reference and runs between receptions
   always_comb begin
      local_d = local_q + NW'(1);
      good_d = good_q;
      locked_d = locked_q;
      sec_d = sec_q + SCW'(1);
      age_d = age_q;
      loss_d = 1'b0;
      ncr_err = NCR_VALUE - local_q;
      if (ncr_err[NW-1]) begin
         ncr_err = local_q - NCR_VALUE;
      end
      ncr_bad = (ncr_err > NW'(NCR_TOL)) && (good_q != 4'h0 || locked_q);
      if (sec_q == SCW'(SEC_CYC - 1)) begin
         sec_d = '0;
         if (age_q != 4'hf) begin
            age_d = age_q + 4'h1;
         end
      end
      if (NCR_VALID) begin
         local_d = NCR_VALUE;
         sec_d = '0;
         age_d = 4'h0;
         if (ncr_bad) begin
            good_d = 4'h0;
         end else if (good_q != NCR_LOCK_COUNT) begin
            good_d = good_q + 4'h1;
         end
         if (!ncr_bad && good_q == NCR_LOCK_COUNT) begin
            locked_d = 1'b1;
         end
      end
      // Timeout in seconds or a reference jump drops lock
      if (locked_q && ((NCR_VALID && ncr_bad) ||
          (!NCR_VALID && NCR_TIMEOUT_S != 4'h0 && age_q >= NCR_TIMEOUT_S))) begin
         locked_d = 1'b0;
         good_d = 4'h0;
         loss_d = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         local_q <= '0;
         good_q <= 4'h0;
         locked_q <= 1'b0;
         sec_q <= '0;
         age_q <= 4'h0;
         loss_q <= 1'b0;
      end else begin
         local_q <= local_d;
         good_q <= good_d;
         locked_q <= locked_d;
         sec_q <= sec_d;
         age_q <= age_d;
         loss_q <= loss_d;
      end
   end

   // ---------------- Range and delay ----------------
   logic signed [SW-1:0] dx, dy, dz;
   logic signed [2*SW-1:0] sqx, sqy, sqz;
   logic [AW-1:0] acc_q, acc_d;
   logic [RW-1:0] root_q, root_d, trial;
   logic [BW-1:0] rbit_q, rbit_d;
   logic busy_q, busy_d;
   logic spt_seen_q, spt_seen_d;
   logic rvalid_q, rvalid_d;
   logic [RW-1:0] km_q, km_d;
   logic [DW-1:0] dly_q, dly_d;

   // Squared distance, then bitwise square root, then delay
   always_comb begin
      dx = $signed({SAT_X[PW-1], SAT_X}) - $signed({TERM_X[PW-1], TERM_X});
      dy = $signed({SAT_Y[PW-1], SAT_Y}) - $signed({TERM_Y[PW-1], TERM_Y});
      dz = $signed({SAT_Z[PW-1], SAT_Z}) - $signed({TERM_Z[PW-1], TERM_Z});
      sqx = dx * dx;
      sqy = dy * dy;
      sqz = dz * dz;
      acc_d = acc_q;
      root_d = root_q;
      rbit_d = rbit_q;
      busy_d = busy_q;
      spt_seen_d = spt_seen_q;
      rvalid_d = rvalid_q;
      km_d = km_q;
      dly_d = dly_q;
      trial = root_q | (RW'(1) << rbit_q);
      if (busy_q) begin
         if (AW'(trial) * AW'(trial) <= acc_q) begin
            root_d = trial;
         end
         if (rbit_q == '0) begin
            busy_d = 1'b0;
            rvalid_d = 1'b1;
            km_d = root_d;
            dly_d = DW'(root_d) * DW'(NS_PER_KM);
         end else begin
            rbit_d = rbit_q - BW'(1);
         end
      end else if (SPT_VALID || (NIT_VALID && !spt_seen_q)) begin
         // Position table wins; nominal position only without one
         spt_seen_d = spt_seen_q | SPT_VALID;
         acc_d = AW'(sqx) + AW'(sqy) + AW'(sqz);
         root_d = '0;
         rbit_d = BW'(RW - 1);
         busy_d = 1'b1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         acc_q <= '0;
         root_q <= '0;
         rbit_q <= '0;
         busy_q <= 1'b0;
         spt_seen_q <= 1'b0;
         rvalid_q <= 1'b0;
         km_q <= '0;
         dly_q <= '0;
      end else begin
         acc_q <= acc_d;
         root_q <= root_d;
         rbit_q <= rbit_d;
         busy_q <= busy_d;
         spt_seen_q <= spt_seen_d;
         rvalid_q <= rvalid_d;
         km_q <= km_d;
         dly_q <= dly_d;
      end
   end

   // ---------------- Terminal state machine ----------------
   tss_state_t state_q, state_d;
   logic [7:0] tries_q, tries_d;
   logic [LCW-1:0] wait_q, wait_d;
   logic [3:0] miss_q, miss_d;
   logic [1:0] boot_q, boot_d;
   logic [EW-1:0] err_t_q, err_t_d, err_f_q, err_f_d;
   logic fine_run_q, fine_run_d;
   logic btp_seen_q, btp_seen_d, tim_seen_q, tim_seen_d;
   logic logon_req_q, logon_req_d, logged_on_q, logged_on_d;
   logic nv_wr_q, nv_wr_d, nv_data_q, nv_data_d;
   logic fail_q, fail_d;
   logic trf_q, trf_d, acq_q, acq_d, sync_q, sync_d;
   logic last_try, fail_now;

   // Next state, counters and transmit enables
   always_comb begin
      state_d = state_q;
      tries_d = tries_q;
      wait_d = wait_q;
      miss_d = miss_q;
      boot_d = boot_q;
      err_t_d = CORR_VALID ? CORR_ERR_T : err_t_q;
      err_f_d = CORR_VALID ? CORR_ERR_F : err_f_q;
      fine_run_d = fine_run_q;
      btp_seen_d = btp_seen_q | BTP_VALID;
      tim_seen_d = tim_seen_q | TIM_VALID;
      logon_req_d = 1'b0;
      logged_on_d = logged_on_q;
      nv_wr_d = 1'b0;
      nv_data_d = nv_data_q;
      fail_d = 1'b0;
      fail_now = 1'b0;
      last_try = ({1'b0, tries_q} + 9'h001) >= {1'b0, MAX_TRIES};
      if (boot_q != BOOT_DONE) begin
         boot_d = boot_q + 2'h1;
      end
      if (TIM_VALID && TIM_TX_DISABLE && (state_q inside {ST_RX_SYNC, ST_LOGON,
          ST_COARSE, ST_FINE_RDY, ST_FINE_SYNC})) begin
         state_d = ST_HOLD;
         nv_wr_d = 1'b1;
         nv_data_d = 1'b1;
         logged_on_d = 1'b0;
      end else if (loss_q && !(state_q inside {ST_INACTIVE, ST_HOLD})) begin
         state_d = ST_INACTIVE;
         logged_on_d = 1'b0;
      end else begin
         case (state_q)
            ST_INACTIVE: begin
               // Stored hold is read once the synchroniser has settled
               if (boot_q == BOOT_SAMPLE) begin
                  nv_data_d = nv_hold_s;
                  state_d = nv_hold_s ? ST_HOLD : ST_INIT;
               end else if (boot_q == BOOT_DONE) begin
                  state_d = ST_INIT;
               end
            end
            ST_INIT: begin
               if (locked_q && rvalid_q && btp_seen_q && tim_seen_q) begin
                  state_d = ST_RX_SYNC;
               end
            end
            ST_HOLD: begin
               if (TIM_VALID && !TIM_TX_DISABLE) begin
                  state_d = ST_RX_SYNC;
                  nv_wr_d = 1'b1;
                  nv_data_d = 1'b0;
               end
            end
            ST_RX_SYNC: begin
               if (LOGON_START) begin
                  state_d = ST_LOGON;
                  logon_req_d = 1'b1;
                  wait_d = '0;
                  tries_d = TRIES_RST;
               end
            end
            ST_LOGON: begin
               if (TIM_VALID && TIM_LOGON_ACK) begin
                  logged_on_d = 1'b1;
                  tries_d = TRIES_RST;
                  fine_run_d = over_thr(err_t_d, err_f_d, FINE_THR_T, FINE_THR_F);
                  state_d = TIM_ACQ_DESC ? ST_COARSE : ST_FINE_RDY;
               end else if (wait_q == LCW'(LOGON_CYC - 1)) begin
                  // No answer: retry until the tries run out
                  if (last_try) begin
                     fail_now = 1'b1;
                  end else begin
                     tries_d = tries_q + 8'h01;
                     logon_req_d = 1'b1;
                     wait_d = '0;
                  end
               end else begin
                  wait_d = wait_q + LCW'(1);
               end
            end
            ST_COARSE: begin
               if (CORR_VALID) begin
                  if (!over_thr(CORR_ERR_T, CORR_ERR_F, COARSE_THR_T, COARSE_THR_F)) begin
                     state_d = ST_FINE_RDY;
                     tries_d = TRIES_RST;
                     fine_run_d = over_thr(CORR_ERR_T, CORR_ERR_F, FINE_THR_T, FINE_THR_F);
                  end else if (last_try) begin
                     fail_now = 1'b1;
                  end else begin
                     tries_d = tries_q + 8'h01;
                  end
               end
            end
            ST_FINE_RDY: begin
               if (!fine_run_q) begin
                  state_d = ST_FINE_SYNC;
                  miss_d = MISS_RST;
               end else if (CORR_VALID) begin
                  if (!over_thr(CORR_ERR_T, CORR_ERR_F, FINE_THR_T, FINE_THR_F)) begin
                     state_d = ST_FINE_SYNC;
                     miss_d = MISS_RST;
                  end else if (last_try) begin
                     fail_now = 1'b1;
                  end else begin
                     tries_d = tries_q + 8'h01;
                  end
               end
            end
            ST_FINE_SYNC: begin
               // Maintenance: MISS_MAX sync bursts without a correction in between fail
               if (LOGOFF_REQ) begin
                  state_d = ST_RX_SYNC;
                  logged_on_d = 1'b0;
               end else if (CORR_VALID) begin
                  miss_d = MISS_RST;
               end else if (SYNC_SENT) begin
                  if ({28'h0000000, miss_q} + 32'h00000001 >= 32'(MISS_MAX)) begin
                     fail_now = 1'b1;
                  end else begin
                     miss_d = miss_q + 4'h1;
                  end
               end
            end
            default: begin
               state_d = ST_INACTIVE;
            end
         endcase
      end
      if (fail_now) begin
         state_d = ST_INIT;
         fail_d = 1'b1;
         logged_on_d = 1'b0;
         fine_run_d = 1'b0;
      end
      // Restart of initial sync gathers the tables again
      if (state_d == ST_INIT && state_q != ST_INIT) begin
         btp_seen_d = BTP_VALID;
         tim_seen_d = TIM_VALID;
      end
      trf_d = (state_d == ST_FINE_SYNC);
      acq_d = (state_d == ST_COARSE);
      sync_d = (state_d == ST_FINE_RDY && fine_run_d) || (state_d == ST_FINE_SYNC);
   end

   always_ff @(posedge CORE_CLK) begin
      if (!RESET_N) begin
         state_q <= STATE_RST;
         tries_q <= TRIES_RST;
         wait_q <= '0;
         miss_q <= MISS_RST;
         boot_q <= 2'h0;
         err_t_q <= '0;
         err_f_q <= '0;
         fine_run_q <= 1'b0;
         btp_seen_q <= 1'b0;
         tim_seen_q <= 1'b0;
         logon_req_q <= 1'b0;
         logged_on_q <= 1'b0;
         nv_wr_q <= 1'b0;
         nv_data_q <= 1'b0;
         fail_q <= 1'b0;
         trf_q <= 1'b0;
         acq_q <= 1'b0;
         sync_q <= 1'b0;
      end else begin
         state_q <= state_d;
         tries_q <= tries_d;
         wait_q <= wait_d;
         miss_q <= miss_d;
         boot_q <= boot_d;
         err_t_q <= err_t_d;
         err_f_q <= err_f_d;
         fine_run_q <= fine_run_d;
         btp_seen_q <= btp_seen_d;
         tim_seen_q <= tim_seen_d;
         logon_req_q <= logon_req_d;
         logged_on_q <= logged_on_d;
         nv_wr_q <= nv_wr_d;
         nv_data_q <= nv_data_d;
         fail_q <= fail_d;
         trf_q <= trf_d;
         acq_q <= acq_d;
         sync_q <= sync_d;
      end
   end

   // Outputs straight from flip-flops
   assign STATE = state_q;
   assign TRAFFIC_TX_EN = trf_q;
   assign ACQ_TX_EN = acq_q;
   assign SYNC_TX_EN = sync_q;
   assign LOGON_REQ = logon_req_q;
   assign LOGGED_ON = logged_on_q;
   assign NV_HOLD_WR = nv_wr_q;
   assign NV_HOLD_DATA = nv_data_q;
   assign NCR_LOCKED = locked_q;
   assign NCR_LOSS_EVT = loss_q;
   assign PROC_FAIL_EVT = fail_q;
   assign RANGE_VALID = rvalid_q;
   assign RANGE_KM = km_q;
   assign PROP_DELAY_NS = dly_q;

endmodule // tss_sync_fsm
`default_nettype wire

/* File: verif/tss_sync_fsm_asserts.sv */
`timescale 1ns/100ps
`default_nettype none
// Sequencer checks
module tss_sync_fsm_chk
   import tss_pkg::*;
(
   // Clock and reset
   input wire logic CORE_CLK,
   input wire logic RESET_N,
   // Message strobes
   input wire logic SPT_VALID,
   input wire logic NIT_VALID,
   input wire logic TIM_VALID,
   input wire logic TIM_TX_DISABLE,
   input wire logic TIM_LOGON_ACK,
   input wire logic TIM_ACQ_DESC,
   input wire logic LOGOFF_REQ,
   input wire logic SYNC_SENT,
   // Design outputs
   input wire logic NV_HOLD_WR,
   input wire logic NV_HOLD_DATA,
   input wire logic [7:0] STATE,
   input wire logic TRAFFIC_TX_EN,
   input wire logic ACQ_TX_EN,
   input wire logic SYNC_TX_EN,
   input wire logic LOGGED_ON,
   input wire logic NCR_LOCKED,
   input wire logic NCR_LOSS_EVT,
   input wire logic PROC_FAIL_EVT,
   input wire logic RANGE_VALID
);
   default clocking @(posedge CORE_CLK);
   endclocking
   default disable iff (!RESET_N);
   // Helper terms
   wire logic trig = SPT_VALID | NIT_VALID;
   wire logic dis = TIM_VALID & TIM_TX_DISABLE;
   wire logic synced = |STATE[7:3];
   wire logic ack = TIM_VALID & TIM_LOGON_ACK & !TIM_TX_DISABLE & !NCR_LOSS_EVT;
   // Restart via inactive
   sequence seq_restart;
      STATE == 8'h01 && !TRAFFIC_TX_EN ##1 STATE == 8'h02;
   endsequence
   AST_TRF_FINE: assert property (TRAFFIC_TX_EN |-> STATE == 8'h80)
      else $error("traffic outside fine sync");
   AST_LOGON_RX: assert property (STATE == 8'h10 && $past(STATE) != 8'h10 |-> $past(STATE) == 8'h08)
      else $error("logon not from receive sync");
   AST_TXDIS: assert property (dis && synced |=> STATE == 8'h04 && NV_HOLD_WR && NV_HOLD_DATA && !TRAFFIC_TX_EN && !LOGGED_ON)
      else $error("tx disable");
   AST_HOLD_STAY: assert property (STATE == 8'h04 && !(TIM_VALID && !TIM_TX_DISABLE) |=> STATE == 8'h04)
      else $error("hold left");
   AST_HOLD_REL: assert property (STATE == 8'h04 && TIM_VALID && !TIM_TX_DISABLE |=> STATE == 8'h08 && NV_HOLD_WR && !NV_HOLD_DATA)
      else $error("hold release wrong");
   AST_ACK_SKIP: assert property (STATE == 8'h10 && ack && !TIM_ACQ_DESC |=> STATE == 8'h40 && LOGGED_ON)
      else $error("no descriptor");
   AST_ACK_DESC: assert property (STATE == 8'h10 && ack && TIM_ACQ_DESC |=> STATE == 8'h20 && ACQ_TX_EN && LOGGED_ON)
      else $error("descriptor");
   AST_LOSS: assert property (NCR_LOSS_EVT && !(STATE inside {8'h01, 8'h04}) && !dis |=> seq_restart)
      else $error("loss did not restart");
   AST_LOSS_EVT: assert property ($fell(NCR_LOCKED) |-> NCR_LOSS_EVT)
      else $error("lock fell without event");
   AST_FAIL: assert property (PROC_FAIL_EVT |-> STATE == 8'h02 && !LOGGED_ON && !TRAFFIC_TX_EN)
      else $error("fail not init");
   AST_LOGOFF: assert property (STATE == 8'h80 && LOGOFF_REQ && !TIM_VALID && !SYNC_SENT && !NCR_LOSS_EVT |=> STATE == 8'h08 && !LOGGED_ON && !SYNC_TX_EN)
      else $error("logoff wrong");
   AST_RANGE: assert property ($rose(RANGE_VALID) |-> $past(trig, 19))
      else $error("range latency wrong");
   AST_RX_ENTRY: assert property (STATE == 8'h08 && $past(STATE) == 8'h02 |-> NCR_LOCKED && RANGE_VALID)
      else $error("early rx sync");
endmodule // tss_sync_fsm_chk

bind tss_sync_fsm tss_sync_fsm_chk u_chk (.CORE_CLK, .RESET_N, .SPT_VALID, .NIT_VALID,
   .TIM_VALID, .TIM_TX_DISABLE, .TIM_LOGON_ACK, .TIM_ACQ_DESC, .LOGOFF_REQ, .SYNC_SENT,
   .NV_HOLD_WR, .NV_HOLD_DATA, .STATE, .TRAFFIC_TX_EN, .ACQ_TX_EN, .SYNC_TX_EN, .LOGGED_ON,
   .NCR_LOCKED, .NCR_LOSS_EVT, .PROC_FAIL_EVT, .RANGE_VALID);
`default_nettype wire

/* File: verif/tss_ncc_model.sv */
`timescale 1ns/100ps
`default_nettype none
// Control centre clock reference
module tss_ncc_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Control
   input wire logic run,
   // Reference out
   output logic ref_valid,
   output logic [31:0] ref_value
);
   logic [31:0] time_q;
   logic [2:0] gap_q;
   // Reference every eighth cycle
   always_ff @(posedge clk) begin
      time_q <= rst_n ? time_q + 32'h1 : 32'h0;
      gap_q <= rst_n ? gap_q + 3'h1 : 3'h0;
   end
   // Value inverted outside a reference
   assign ref_valid = run && gap_q == 3'h7;
   assign ref_value = ref_valid ? time_q : ~time_q;
endmodule // tss_ncc_model
`default_nettype wire

/* File: verif/tss_sync_fsm_bench.sv */
`timescale 1ns/100ps
`default_nettype none
// Sequencer bench
module tss_sync_fsm_bench
   import tss_pkg::*;
;
   localparam logic [10:0] M_PLAN = 11'h1, M_INFO = 11'h2, M_DIS = 11'h4, M_ACK = 11'h8;
   localparam logic [10:0] M_DESC = 11'h10, M_CORR = 11'h20, M_LGN = 11'h40, M_OFF = 11'h80;
   localparam logic [10:0] M_POS = 11'h200, M_NOM = 11'h400;
   logic clk = 1'b0, rst_n = 1'b0, run = 1'b1, nv_q = 1'b0;
   logic [10:0] m = 11'h0;
   logic [15:0] err = 16'h0, sx = 16'h0, sy = 16'h0, sz = 16'h0, cthr, fthr;
   logic [31:0] seed = 32'hda896923, ref_d;
   int tx, ty, tz, cyc = 0, n_fail = 0, checks_done = 0, nreq;
   logic ref_v, nvwr, nvd, tr, crs_en, syn, lreq, lon, lck, loss, fail, rv;
   logic [7:0] state;
   logic [17:0] rkm, ekm;
   logic [29:0] rdl;
   // Clock
   always #2 clk = ~clk;
   tss_ncc_model u_ncc (.clk(clk), .rst_n(rst_n), .run(run), .ref_valid(ref_v),
      .ref_value(ref_d));
   tss_sync_fsm #(.SEC_CYC(50), .LOGON_CYC(20)) DUT (
      .CORE_CLK(clk), .RESET_N(rst_n), .NCR_VALID(ref_v), .NCR_VALUE(ref_d),
      .NCR_TIMEOUT_S(4'h2), .SPT_VALID(m[9]), .NIT_VALID(m[10]), .SAT_X(sx), .SAT_Y(sy),
      .SAT_Z(sz), .TERM_X(tx[15:0]), .TERM_Y(ty[15:0]), .TERM_Z(tz[15:0]), .BTP_VALID(m[0]),
      .TIM_VALID(m[1]), .TIM_TX_DISABLE(m[2]), .TIM_LOGON_ACK(m[3]), .TIM_ACQ_DESC(m[4]),
      .CORR_VALID(m[5]), .CORR_ERR_T(err), .CORR_ERR_F(err), .COARSE_THR_T(cthr),
      .COARSE_THR_F(cthr), .FINE_THR_T(fthr), .FINE_THR_F(fthr), .MAX_TRIES(8'h02),
      .LOGON_START(m[6]), .LOGOFF_REQ(m[7]), .SYNC_SENT(m[8]), .NV_HOLD_IN(nv_q),
      .NV_HOLD_WR(nvwr), .NV_HOLD_DATA(nvd), .STATE(state), .TRAFFIC_TX_EN(tr),
      .ACQ_TX_EN(crs_en), .SYNC_TX_EN(syn), .LOGON_REQ(lreq), .LOGGED_ON(lon),
      .NCR_LOCKED(lck), .NCR_LOSS_EVT(loss), .PROC_FAIL_EVT(fail), .RANGE_VALID(rv),
      .RANGE_KM(rkm), .PROP_DELAY_NS(rdl));
   // Hold store
   always @(posedge clk) begin
      if (nvwr === 1'b1) nv_q <= nvd;
   end
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Expected range
   function automatic logic [17:0] km(input int x, input int y, input int z);
      int s;
      int r;
      s = (x - tx) * (x - tx) + (y - ty) * (y - ty) + (z - tz) * (z - tz);
      r = 0;
      while ((r + 1) * (r + 1) <= s) r++;
      return 18'(r);
   endfunction
   task automatic test_done();
      $display("checks %0d failures %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_fail++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask
   // Strobe pulse
   task automatic send(input logic [10:0] v, input logic [15:0] e);
      @(posedge clk);
      m <= v;
      err <= e;
      @(posedge clk);
      m <= 11'h0;
      #1;
   endtask
   task automatic step();
      @(posedge clk);
      #1;
   endtask
   task automatic wait_st(input logic [7:0] s, input int lim);
      for (int i = 0; i < lim && state !== s; i++) step();
      chk("state", s, state);
   endtask
   // Range check
   task automatic rng(input logic [10:0] src, input logic take);
      logic [15:0] a, b, c;
      a = 16'(xs() & 32'h3ff);
      b = 16'(xs() & 32'h3ff);
      c = 16'(xs() & 32'h3ff);
      @(posedge clk);
      sx <= a;
      sy <= b;
      sz <= c;
      send(src, err);
      if (take) ekm = km(a, b, c);
      repeat (19) step();
      chk("range", ekm, rkm);
      chk("delay", 30'(ekm) * 30'hd08, rdl);
   endtask
   // Hang guard
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         n_fail++;
         test_done();
      end
   end
   initial begin
      tx = int'(xs() & 32'hff);
      ty = int'(xs() & 32'hff);
      tz = int'(xs() & 32'hff);
      cthr = 16'h0100 | 16'(xs() & 32'hff);
      fthr = 16'h0010 | 16'(xs() & 32'hf);
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      // Nominal, table, late nominal
      rng(M_NOM, 1'b1);
      rng(M_POS, 1'b1);
      rng(M_NOM, 1'b0);
      send(M_PLAN | M_INFO, 16'h0);
      wait_st(ST_RX_SYNC, 200);
      // No descriptor, fine skipped
      send(M_LGN, 16'h0);
      chk("logon req", 1, lreq);
      chk("traffic", 0, tr);
      send(M_INFO | M_ACK | M_CORR, 16'(xs() & 32'hf));
      chk("state", ST_FINE_RDY, state);
      step();
      chk("state", ST_FINE_SYNC, state);
      chk("traffic", 1, tr);
      send(M_OFF, 16'h0);
      chk("logged on", 0, lon);
      chk("state", ST_RX_SYNC, state);
      // Descriptor, coarse, fine
      send(M_LGN, 16'h0);
      send(M_INFO | M_ACK | M_DESC, 16'h0);
      chk("coarse burst", 1, crs_en);
      send(M_CORR, 16'h0200 | 16'(xs() & 32'hff));
      chk("state", ST_COARSE, state);
      send(M_CORR, 16'h0020 | 16'(xs() & 32'h1f));
      step();
      chk("state", ST_FINE_RDY, state);
      chk("sync burst", 1, syn);
      send(M_CORR, 16'(xs() & 32'hf));
      chk("state", ST_FINE_SYNC, state);
      send(M_INFO | M_DIS, 16'h0);
      chk("state", ST_HOLD, state);
      chk("traffic", 0, tr);
      // Hold across reset
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (5) @(posedge clk);
      rst_n <= 1'b1;
      wait_st(ST_HOLD, 10);
      send(M_INFO | M_DIS, 16'h0);
      send(M_LGN, 16'h0);
      chk("state", ST_HOLD, state);
      send(M_INFO, 16'h0);
      chk("state", ST_RX_SYNC, state);
      chk("nv data", 0, nvd);
      // Logon tries run out
      send(M_LGN, 16'h0);
      nreq = 0;
      for (int i = 0; i < 200 && fail !== 1'b1; i++) begin
         nreq += int'(lreq === 1'b1);
         step();
      end
      chk("logon requests", 2, nreq);
      chk("state", ST_INIT, state);
      // Reference loss
      chk("locked", 1, lck);
      @(posedge clk);
      run <= 1'b0;
      for (int i = 0; i < 300 && loss !== 1'b1; i++) step();
      chk("loss event", 1, loss);
      chk("locked", 0, lck);
      step();
      chk("state", ST_INACTIVE, state);
      step();
      chk("state", ST_INIT, state);
      test_done();
   end
endmodule // tss_sync_fsm_bench
`default_nettype wire
